// File: logic/cesq_pkg.sv
// Purpose: Shared constants and types for the exception sequencer.
// Assumes: One 40 MHz clock; software reaches registers over AHB-Lite.
// Notes: Source 0 and 1 are external requests, 2 to 20 are internal.
// Operation
// - Single-chip mode: any access to 8000..FB7F is an address error.
// - Single-chip mode, RAM disabled: access to FB80..FF7F errors.
// - Trace flag set: trace exception after each instruction.
// - Trace sequence clears trace flag, keeps mask level.
// - Status word pushed for trace carries trace flag as one.
// - Address error beats trace on one instruction; trace is lost.
// - Maskable levels 0 to 7; nonmaskable request counts as level 8.
// - Accept by level against mask; others stay pending, ordered.
// - Accepted source with transfer-select set starts transfer engine.
// - CPU halts while an interrupt-started transfer runs.
// - CPU interrupt clears trace flag, mask takes accepted level.
// - Return from handler restores the earlier mask level.
// - Invalid opcode: push detection PC, clear trace, keep mask.
// - Unconditional trap always traps, vector number 0 to 15.
// - Overflow trap traps only when overflow flag is one.
// - Unsigned divide by zero raises zero-divide exception.
// - Trap, zero-divide keep mask; pending interrupt follows at once.
// - In deferral cases all asynchronous exceptions wait one instruction.
// - After status-modifying ops, wait for a following other op.
// - Out of reset nothing is accepted before first instruction.
// - After a transfer one instruction runs before any interrupt.
// - Address error clears trace flag, keeps mask level.
// - Nonmaskable sequence clears trace flag, sets mask to 7.
package cesq_pkg;
  localparam int NSRC = 21;
  localparam int IDXW = 5;
  localparam int LVLW = 3;
  localparam logic [15:0] UNMAP_LO = 16'h8000;
  localparam logic [15:0] UNMAP_HI = 16'hFB7F;
  localparam logic [15:0] RAM_LO = 16'hFB80;
  localparam logic [15:0] RAM_HI = 16'hFF7F;
  localparam logic [LVLW-1:0] MASK_TOP = 3'h7;
  localparam logic RAM_EN_RST = 1'b1;
  localparam int HT_ACTIVE = 1;
  localparam int BIT_SINGLE = 0;
  localparam int BIT_RAM_EN = 1;
  localparam int PRIO_PER = 8;
  localparam int PRIO_FLD = 4;
  localparam int STAT_TRACE = 3;
  localparam int STAT_ST = 4;
  localparam int STAT_NMI = 6;
  localparam int STAT_AE = 7;
  localparam logic [5:0] OFF_TOP = 6'h05;

  // Word index of each register; byte offset is four times the index.
  typedef enum logic [2:0] {
    RG_CTRL = 3'h0, RG_PRIO0 = 3'h1, RG_PRIO1 = 3'h2,
    RG_PRIO2 = 3'h3, RG_XSEL = 3'h4, RG_STAT = 3'h5, RG_NONE = 3'h7
  } cesq_reg_e;

  typedef enum logic [3:0] {
    EX_NONE = 4'h0, EX_ADDR = 4'h1, EX_INVALID = 4'h2, EX_TRAP = 4'h3,
    EX_TRAPV = 4'h4, EX_ZDIV = 4'h5, EX_TRACE = 4'h6, EX_NMI = 4'h7,
    EX_IRQ = 4'h8
  } cesq_exc_e;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00, ST_REQ = 2'b01, ST_XFER = 2'b10
  } cesq_st_e;

  typedef struct packed {
    logic trace;
    logic [LVLW-1:0] mask;
  } cesq_stw_s;

  typedef struct packed {
    logic done;
    logic ctrl_op;
    logic stw_wr;
    cesq_stw_s stw_val;
    logic invalid;
    logic trap;
    logic [3:0] trap_vec;
    logic ovf_trap;
    logic ovf_flag;
    logic div_op;
    logic div_zero;
    logic [15:0] pc;
  } cesq_instr_s;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } cesq_acc_s;
endpackage

// File: logic/cesq_addr_chk.sv
// Purpose: Flags accesses that hit no memory in single-chip mode.
// Assumes: One access strobe per bus cycle of the CPU.
// Notes: Purely combinational; the caller registers the result.
module cesq_addr_chk
  import cesq_pkg::*;
(
  input wire cesq_acc_s acc,
  input wire logic single,
  input wire logic ram_en,
  output logic err
);
  logic in_gap;
  logic in_ram;

  // Range compares for the unmapped gap and the RAM window.
  assign in_gap = acc.addr >= UNMAP_LO && acc.addr <= UNMAP_HI;
  assign in_ram = acc.addr >= RAM_LO && acc.addr <= RAM_HI;
  // Only single-chip mode has no external memory to catch these.
  assign err = acc.valid && single &&
               (in_gap || (in_ram && !ram_en));
endmodule

// File: logic/cesq_prio.sv
// Purpose: Picks the highest-level pending maskable source.
// Assumes: Levels are software-set, 0 lowest.
// Notes: Equal levels resolve to the lowest source number.
module cesq_prio
  import cesq_pkg::*;
(
  input wire logic [NSRC-1:0] req,
  input wire logic [NSRC-1:0][LVLW-1:0] lvl,
  output logic any,
  output logic [IDXW-1:0] idx,
  output logic [LVLW-1:0] level
);
  // Scan downward so the lowest index wins a tie.
  always_comb
  begin
    any = 1'b0;
    idx = '0;
    level = '0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (req[i] && (!any || lvl[i] >= level))
      begin
        any = 1'b1;
        idx = IDXW'(i);
        level = lvl[i];
      end
    end
  end
endmodule

// File: logic/cesq_top.sv
// Purpose: Exception detection and acceptance for the CPU sequencer.
// Assumes: Sequencer completes no instruction while a request waits.
// Notes: Registers answer with zero wait states over AHB-Lite.
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
module cesq_top
  import cesq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire cesq_instr_s instr,
  input wire cesq_acc_s acc,
  input wire logic nmi_req,
  input wire logic [NSRC-1:0] int_req,
  input wire logic exc_ack,
  output logic exc_req,
  output cesq_exc_e exc_id,
  output logic [IDXW-1:0] exc_vec,
  output cesq_stw_s push_stw,
  output logic [15:0] push_pc,
  output cesq_stw_s status_word,
  input wire logic xfer_done,
  output logic xfer_start,
  output logic [IDXW-1:0] xfer_src,
  output logic cpu_halt
);
  typedef struct packed {
    logic a_sel;
    logic a_wr;
    logic [7:0] a_off;
    logic [31:0] rdata;
    logic rdy;
    logic resp;
    logic single;
    logic ram_en;
    logic [NSRC-1:0][LVLW-1:0] prio;
    logic [NSRC-1:0] xsel;
    cesq_stw_s stw;
    logic addr_err;
    logic nmi_pend;
    logic trace_pend;
    logic chain;
    cesq_st_e st;
    logic req;
    cesq_exc_e id;
    logic [IDXW-1:0] vec;
    logic [LVLW-1:0] lvl;
    cesq_stw_s push;
    logic [15:0] pc;
    logic start;
    logic [IDXW-1:0] src;
    logic halt;
  } cesq_state_s;

  // Mask starts at the top so no maskable interrupt slips in before the stack is set.
  localparam cesq_state_s S_RST = '{
    stw: '{trace: 1'b0, mask: MASK_TOP},
    ram_en: RAM_EN_RST, rdy: 1'b1, st: ST_RUN, id: EX_NONE,
    default: '0};

  cesq_state_s s_q;
  cesq_state_s s_d;
  logic ae_now;
  logic p_any;
  logic [IDXW-1:0] p_idx;
  logic [LVLW-1:0] p_lvl;

  // Word index of a byte offset, or none for holes and offsets that are not word-aligned.
  function automatic cesq_reg_e widx(input logic [7:0] off);
    if (off[1:0] != 2'b00 || off[7:2] > OFF_TOP)
      return RG_NONE;
    return cesq_reg_e'(off[4:2]);
  endfunction

  cesq_addr_chk u_chk (
    .acc(acc),
    .single(s_q.single),
    .ram_en(s_q.ram_en),
    .err(ae_now)
  );

  cesq_prio u_prio (
    .req(int_req),
    .lvl(s_q.prio),
    .any(p_any),
    .idx(p_idx),
    .level(p_lvl)
  );

  // Next-state logic: bus slave, pending flags and the sequencer.
  always_comb
  begin
    cesq_reg_e rg;
    int pw;
    int src;
    logic fire;
    logic ae;
    rg = RG_NONE;
    pw = 0;
    src = 0;
    fire = 1'b0;
    ae = s_q.addr_err | ae_now;
    s_d = s_q;
    s_d.start = 1'b0;

    // Address phase: read data is fetched now so it can be a flop
    // in the data phase. A read right after a write sees old data.
    if (hready)
    begin
      rg = widx(haddr[7:0]);
      pw = int'(rg) - int'(RG_PRIO0);
      s_d.a_sel = hsel && htrans[HT_ACTIVE];
      s_d.a_wr = hwrite;
      s_d.a_off = haddr[7:0];
      s_d.rdata = '0;
      if (hsel && htrans[HT_ACTIVE] && !hwrite)
      begin
        case (rg)
          RG_CTRL:
          begin
            s_d.rdata[BIT_SINGLE] = s_q.single;
            s_d.rdata[BIT_RAM_EN] = s_q.ram_en;
          end
          RG_PRIO0, RG_PRIO1, RG_PRIO2:
          begin
            for (int k = 0; k < PRIO_PER; k++)
            begin
              src = pw * PRIO_PER + k;
              if (src < NSRC)
                s_d.rdata[k*PRIO_FLD +: LVLW] = s_q.prio[src];
            end
          end
          RG_XSEL: s_d.rdata[NSRC-1:0] = s_q.xsel;
          RG_STAT:
          begin
            s_d.rdata[LVLW-1:0] = s_q.stw.mask;
            s_d.rdata[STAT_TRACE] = s_q.stw.trace;
            s_d.rdata[STAT_ST +: 2] = s_q.st;
            s_d.rdata[STAT_NMI] = s_q.nmi_pend;
            s_d.rdata[STAT_AE] = s_q.addr_err;
          end
          default: s_d.rdata = '0;
        endcase
      end
    end

    // Data phase of a write; unmapped and status writes are dropped.
    if (s_q.a_sel && s_q.a_wr)
    begin
      rg = widx(s_q.a_off);
      pw = int'(rg) - int'(RG_PRIO0);
      case (rg)
        RG_CTRL:
        begin
          s_d.single = hwdata[BIT_SINGLE];
          s_d.ram_en = hwdata[BIT_RAM_EN];
        end
        RG_PRIO0, RG_PRIO1, RG_PRIO2:
        begin
          for (int k = 0; k < PRIO_PER; k++)
          begin
            src = pw * PRIO_PER + k;
            if (src < NSRC)
              s_d.prio[src] = hwdata[k*PRIO_FLD +: LVLW];
          end
        end
        RG_XSEL: s_d.xsel = hwdata[NSRC-1:0];
        default: s_d.xsel = s_q.xsel;
      endcase
    end

    // Sticky causes; a new event in the clearing cycle is kept.
    if (ae_now)
      s_d.addr_err = 1'b1;
    if (nmi_req)
      s_d.nmi_pend = 1'b1;
    // Status-word writes from the sequencer, including the restore
    // of the saved word on return from a handler.
    if (instr.stw_wr)
      s_d.stw = instr.stw_val;

    case (s_q.st)
      ST_RUN:
      begin
        s_d.id = EX_NONE;
        s_d.vec = '0;
        if (instr.done)
          s_d.pc = instr.pc;
        if (instr.done && instr.ctrl_op)
        begin
          // Everything asynchronous waits; a due trace is remembered.
          if (s_q.stw.trace)
            s_d.trace_pend = 1'b1;
        end
        else if (instr.done)
        begin
          s_d.trace_pend = 1'b0;
          if (ae)
            s_d.id = EX_ADDR;
          else if (instr.invalid)
            s_d.id = EX_INVALID;
          else if (instr.trap)
          begin
            s_d.id = EX_TRAP;
            s_d.vec = IDXW'(instr.trap_vec);
          end
          else if (instr.ovf_trap && instr.ovf_flag)
            s_d.id = EX_TRAPV;
          else if (instr.div_op && instr.div_zero)
            s_d.id = EX_ZDIV;
          else if (s_q.stw.trace || s_q.trace_pend)
            s_d.id = EX_TRACE;
        end
        // Interrupts are judged only at an instruction end or right after a trap-type acknowledge, so the
        // first instruction after reset or a transfer always runs.
        fire = (instr.done && !instr.ctrl_op) || s_q.chain;
        s_d.chain = 1'b0;
        if (s_d.id == EX_NONE && fire)
        begin
          if (s_q.nmi_pend)
            s_d.id = EX_NMI;
          else if (p_any && p_lvl > s_q.stw.mask)
          begin
            s_d.lvl = p_lvl;
            s_d.vec = p_idx;
            if (s_q.xsel[p_idx])
            begin
              s_d.start = 1'b1;
              s_d.src = p_idx;
              s_d.halt = 1'b1;
              s_d.st = ST_XFER;
            end
            else
              s_d.id = EX_IRQ;
          end
        end
        if (s_d.id != EX_NONE)
        begin
          s_d.req = 1'b1;
          s_d.st = ST_REQ;
          s_d.push = s_q.stw;
          // The saved word keeps tracing alive across the handler.
          if (s_d.id == EX_TRACE)
            s_d.push.trace = 1'b1;
        end
      end
      ST_REQ:
      begin
        // Request and identifier hold until the sequencer takes them.
        if (exc_ack)
        begin
          s_d.req = 1'b0;
          s_d.st = ST_RUN;
          s_d.stw.trace = 1'b0;
          case (s_q.id)
            EX_NMI:
            begin
              s_d.stw.mask = MASK_TOP;
              s_d.nmi_pend = nmi_req;
            end
            EX_IRQ: s_d.stw.mask = s_q.lvl;
            EX_ADDR:
            begin
              s_d.addr_err = ae_now;
              s_d.trace_pend = 1'b0;
            end
            EX_TRAP, EX_TRAPV, EX_ZDIV:
              s_d.chain = 1'b1;
            default: s_d.chain = 1'b0;
          endcase
        end
      end
      ST_XFER:
      begin
        // The CPU stays stopped until the engine reports the end.
        if (xfer_done)
        begin
          s_d.halt = 1'b0;
          s_d.st = ST_RUN;
        end
      end
      default: s_d.st = ST_RUN;
    endcase
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_q <= S_RST;
    else
      s_q <= s_d;
  end

  // Every output is a field of the state register.
  assign hreadyout = s_q.rdy;
  assign hresp = s_q.resp;
  assign hrdata = s_q.rdata;
  assign exc_req = s_q.req;
  assign exc_id = s_q.id;
  assign exc_vec = s_q.vec;
  assign push_stw = s_q.push;
  assign push_pc = s_q.pc;
  assign status_word = s_q.stw;
  assign xfer_start = s_q.start;
  assign xfer_src = s_q.src;
  assign cpu_halt = s_q.halt;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_req_held: assert property (exc_req && !exc_ack |=>
    exc_req && $stable(exc_id)) else $error("request dropped early");
  a_halt_xfer: assert property ((xfer_start |-> cpu_halt) and
    (cpu_halt && !xfer_done |=> cpu_halt)) else $error("no halt");
  a_nmi_mask: assert property (exc_req && exc_ack &&
    exc_id == EX_NMI |=> status_word.mask == MASK_TOP &&
    !status_word.trace) else $error("bad mask after nmi");
  a_irq_mask: assert property (exc_req && exc_ack &&
    exc_id == EX_IRQ && !instr.stw_wr |=>
    status_word.mask == $past(s_q.lvl) && !status_word.trace)
    else $error("mask not loaded");
  a_trace_push: assert property (exc_req &&
    exc_id == EX_TRACE |-> push_stw.trace)
    else $error("trace flag not saved");
  a_addr_catch: assert property (acc.valid && s_q.single &&
    acc.addr >= UNMAP_LO && acc.addr <= UNMAP_HI |=>
    s_q.addr_err || exc_id == EX_ADDR) else $error("gap missed");
  a_ctrl_defer: assert property (s_q.st == ST_RUN &&
    instr.done && instr.ctrl_op && !s_q.chain |=> !exc_req)
    else $error("not deferred");
  a_trap_keep: assert property (exc_req && exc_ack &&
    exc_id inside {EX_TRAP, EX_ZDIV} && !instr.stw_wr |=>
    status_word.mask == $past(status_word.mask) ##1
    (s_q.st != ST_REQ || exc_id inside {EX_NMI, EX_IRQ}))
    else $error("trap changed mask");

  c_nmi: cover property (exc_req && exc_ack && exc_id == EX_NMI);
  c_xfer: cover property (xfer_start ##[1:20] xfer_done);
  c_trace: cover property (exc_req && exc_id == EX_TRACE);
  c_chain: cover property (exc_id == EX_TRAP && exc_ack
    ##2 exc_id == EX_IRQ);
endmodule

// File: tb/cesq_seq_model.sv
// Purpose: Behavioural sequencer and transfer engine at the far side.
// Assumes: The bench sets both answer delays; a larger value is slower.
// Notes: Never acknowledges a request that is not standing.
module cesq_seq_model
  import cesq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic exc_req,
  input wire logic xfer_start,
  input wire logic [3:0] ack_dly,
  input wire logic [3:0] xfer_dly,
  output logic exc_ack,
  output logic xfer_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ack_n_q, xfer_n_q;
  logic busy_q;
  // -----------------------------------------------------------
  // Answers
  // -----------------------------------------------------------
  // A slow acknowledge proves that the request holds its fields.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      exc_ack <= 1'b0;
      ack_n_q <= 4'h0;
    end
    else
    begin
      exc_ack <= 1'b0;
      if (exc_req && !exc_ack)
      begin
        ack_n_q <= ack_n_q + 4'h1;
        if (ack_n_q >= ack_dly)
        begin
          exc_ack <= 1'b1;
          ack_n_q <= 4'h0;
        end
      end
    end
  end

  // The engine runs for a set length, then reports done once.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      xfer_done <= 1'b0;
      busy_q <= 1'b0;
      xfer_n_q <= 4'h0;
    end
    else
    begin
      xfer_done <= 1'b0;
      if (xfer_start)
      begin
        busy_q <= 1'b1;
        xfer_n_q <= 4'h0;
      end
      else if (busy_q)
      begin
        xfer_n_q <= xfer_n_q + 4'h1;
        if (xfer_n_q >= xfer_dly)
        begin
          xfer_done <= 1'b1;
          busy_q <= 1'b0;
        end
      end
    end
  end
endmodule

// File: tb/cesq_top_test.sv
// Purpose: Self-checking bench for the exception sequencer.
// Assumes: Zero-wait register bus; the partner model answers requests.
// Notes: Tests are sequences of bus, instruction and request calls.
module cesq_top_test
  import cesq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int K_RUN = 0, K_INV = 1, K_TRAP = 2;
  localparam int K_OVF = 3, K_DIV = 4, K_CTRL = 5;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, nmi_req;
  logic exc_ack, exc_req, xfer_done, xfer_start, cpu_halt, e;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [NSRC-1:0] int_req;
  logic [IDXW-1:0] exc_vec, xfer_src;
  logic [15:0] push_pc;
  logic [3:0] ack_dly, xfer_dly;
  cesq_instr_s instr;
  cesq_acc_s acc;
  cesq_exc_e exc_id;
  cesq_stw_s push_stw, status_word;
  int miscompares, num_checks, cycles;
  logic [15:0] rv [7] = '{16'h0002, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0007, 16'h0000};
  logic [15:0] adr [6] = '{16'h7FFF, 16'h8000, 16'hFB7F, 16'hFB80,
    16'hFF7F, 16'hFF80};
  logic [1:0] ctl [3] = '{2'h1, 2'h3, 2'h0};

  cesq_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .instr, .acc, .nmi_req, .int_req, .exc_ack, .exc_req, .exc_id,
    .exc_vec, .push_stw, .push_pc, .status_word, .xfer_done,
    .xfer_start, .xfer_src, .cpu_halt);
  cesq_seq_model partner (.hclk, .hresetn, .exc_req, .xfer_start,
    .ack_dly, .xfer_dly, .exc_ack, .xfer_done);

  // -----------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------
  // Clock of 25 ns period.
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One single word transfer; read data is taken at the data edge.
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  function automatic cesq_instr_s op(input int k, input logic [15:0] x);
    cesq_instr_s i;
    i = '0;
    i.done = 1'b1;
    i.pc = x;
    i.invalid = (k == K_INV);
    i.trap = (k == K_TRAP);
    i.trap_vec = x[3:0];
    i.ovf_trap = (k == K_OVF);
    i.ovf_flag = x[0];
    i.div_op = (k == K_DIV);
    i.div_zero = x[0];
    i.ctrl_op = (k == K_CTRL);
    return i;
  endfunction

  // Drives one cycle of instruction status, then lets the edge land.
  task automatic fire(input cesq_instr_s i);
    @(posedge hclk);
    instr <= i;
    @(posedge hclk);
    instr <= '0;
    #1;
  endtask

  task automatic set_sw(input logic t, input logic [2:0] m);
    cesq_instr_s i;
    i = '0;
    i.stw_wr = 1'b1;
    i.stw_val = {t, m};
    fire(i);
    check(16'(status_word), 16'({t, m}));
  endtask

  task automatic req(input logic [NSRC-1:0] v);
    @(posedge hclk);
    int_req <= v;
  endtask

  task automatic nmi();
    @(posedge hclk);
    nmi_req <= 1'b1;
    @(posedge hclk);
    nmi_req <= 1'b0;
  endtask

  // Checks the request, its identity and vector once, then waits until it is acknowledged.
  task automatic want(input cesq_exc_e id, input logic [4:0] vec);
    for (int n = 0; n < 3 && id != EX_NONE && exc_req !== 1'b1; n++)
    begin
      @(posedge hclk);
      #1;
    end
    check(16'(exc_req), 16'(id != EX_NONE));
    if (id != EX_NONE)
    begin
      check(16'(exc_id), 16'(id));
      check(16'(exc_vec), 16'(vec));
      for (int n = 0; n < 40 && exc_req === 1'b1; n++)
      begin
        @(posedge hclk);
        #1;
      end
    end
  endtask

  // A hang counts as a mismatch and ends the run.
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      miscompares++;
      finish_test();
    end
  end

  // -----------------------------------------------------------
  // Tests
  // -----------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    instr = '0;
    acc = '0;
    nmi_req = 1'b0;
    int_req = '0;
    ack_dly = 4'h1;
    xfer_dly = 4'h3;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    check(16'(status_word), 16'h0007);
    for (int r = 0; r < 7; r++)
    begin
      bus(1'b0, 8'(4 * r), 32'h0000_0000);
      check(rd[15:0], rv[r]);
    end
    bus(1'b1, 8'h18, 32'hFFFF_FFFF);
    bus(1'b1, 8'h14, 32'hFFFF_FFFF);
    bus(1'b0, 8'h18, 32'h0000_0000);
    check(rd[15:0], 16'h0000);
    bus(1'b0, 8'h14, 32'h0000_0000);
    check(rd[15:0], 16'h0007);
    check(16'(hresp), 16'h0000);
    $display("test registers done");
    nmi();
    repeat (4) @(posedge hclk);
    #1;
    check(16'(exc_req), 16'h0000);
    set_sw(1'b0, 3'h2);
    fire(op(K_RUN, 16'h0100));
    want(EX_NMI, 5'h00);
    check(16'(status_word), 16'h0007);
    $display("test reset and nmi done");
    for (int c = 0; c < 3; c++)
    begin
      bus(1'b1, 8'h00, {30'h0000_0000, ctl[c]});
      for (int a = 0; a < 6; a++)
      begin
        e = ctl[c][0] && (adr[a] inside {[16'h8000:16'hFB7F]} ||
          (!ctl[c][1] && adr[a] inside {[16'hFB80:16'hFF7F]}));
        set_sw(1'b1, 3'h4);
        @(posedge hclk);
        acc <= '{1'b1, adr[a]};
        @(posedge hclk);
        acc <= '0;
        fire(op(K_RUN, 16'h0200));
        check(16'(push_stw), 16'h000C);
        want(e ? EX_ADDR : EX_TRACE, 5'h00);
        check(16'(status_word), 16'h0004);
      end
    end
    $display("test address error and trace done");
    set_sw(1'b1, 3'h4);
    fire(op(K_INV, 16'h1234));
    check(push_pc, 16'h1234);
    want(EX_INVALID, 5'h00);
    check(16'(status_word), 16'h0004);
    ack_dly <= 4'h6;
    for (int v = 0; v < 16; v++)
    begin
      fire(op(K_TRAP, 16'(v)));
      want(EX_TRAP, 5'(v));
      check(16'(status_word), 16'h0004);
    end
    ack_dly <= 4'h1;
    fire(op(K_OVF, 16'h0001));
    want(EX_TRAPV, 5'h00);
    fire(op(K_OVF, 16'h0000));
    want(EX_NONE, 5'h00);
    fire(op(K_DIV, 16'h0001));
    want(EX_ZDIV, 5'h00);
    fire(op(K_DIV, 16'h0000));
    want(EX_NONE, 5'h00);
    $display("test traps done");
    bus(1'b1, 8'h04, 32'h3446_5500);
    bus(1'b0, 8'h04, 32'h0000_0000);
    check(rd[15:0], 16'h5500);
    bus(1'b1, 8'h10, 32'h0000_0080);
    set_sw(1'b0, 3'h0);
    req(21'h00_0004);
    fire(op(K_TRAP, 16'h0009));
    want(EX_TRAP, 5'h09);
    want(EX_IRQ, 5'h02);
    check(16'(status_word), 16'h0005);
    req(21'h00_0000);
    set_sw(1'b0, 3'h5);
    req(21'h00_0008);
    fire(op(K_RUN, 16'h0300));
    want(EX_NONE, 5'h00);
    req(21'h00_0018);
    fire(op(K_RUN, 16'h0300));
    want(EX_IRQ, 5'h04);
    check(16'(status_word), 16'h0006);
    req(21'h00_0008);
    set_sw(1'b0, 3'h3);
    fire(op(K_RUN, 16'h0300));
    want(EX_IRQ, 5'h03);
    req(21'h00_0160);
    set_sw(1'b0, 3'h0);
    fire(op(K_RUN, 16'h0300));
    want(EX_IRQ, 5'h05);
    req(21'h00_0100);
    set_sw(1'b0, 3'h0);
    fire(op(K_RUN, 16'h0300));
    want(EX_NONE, 5'h00);
    req(21'h00_0004);
    fire(op(K_CTRL, 16'h0300));
    want(EX_NONE, 5'h00);
    fire(op(K_CTRL, 16'h0300));
    want(EX_NONE, 5'h00);
    fire(op(K_RUN, 16'h0300));
    want(EX_IRQ, 5'h02);
    req(21'h00_0000);
    $display("test interrupts done");
    set_sw(1'b0, 3'h0);
    req(21'h00_0080);
    fire(op(K_RUN, 16'h0400));
    check(16'(xfer_start), 16'h0001);
    check(16'(xfer_src), 16'h0007);
    check(16'(exc_req), 16'h0000);
    req(21'h00_0000);
    nmi();
    #1;
    check(16'(cpu_halt), 16'h0001);
    for (int n = 0; n < 20 && cpu_halt === 1'b1; n++)
    begin
      @(posedge hclk);
      #1;
    end
    repeat (2) @(posedge hclk);
    #1;
    check(16'(exc_req), 16'h0000);
    fire(op(K_RUN, 16'h0400));
    want(EX_NMI, 5'h00);
    $display("test transfer done");
    set_sw(1'b1, 3'h2);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    check(16'(status_word), 16'h0007);
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h00, 32'h0000_0000);
    check(rd[15:0], 16'h0002);
    fire(op(K_RUN, 16'h0500));
    want(EX_NONE, 5'h00);
    check(16'(status_word), 16'h0007);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule
